//--- hdl/sdc_pkg.sv
package sdc_pkg;
    // command pins sampled together on each rising edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdc_cmd_s;

    // internal clock and power condition
    typedef enum {ST_RUN, ST_SUSPEND, ST_PDOWN, ST_SREF} sdc_pwr_e;

    // widths
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 11;
    localparam int ROW_W    = 12;
    localparam int MEM_AW   = 6;
    localparam int FIFO_D   = 4;

    // write word queued towards the array
    typedef struct packed {
        logic [MEM_AW-1:0] idx;
        logic [DATA_W-1:0] data;
    } sdc_wword_s;

    // {ras_n, cas_n, we_n} encodings
    localparam logic [2:0] OP_NOP = 3'h7;
    localparam logic [2:0] OP_BST = 3'h6;
    localparam logic [2:0] OP_RD  = 3'h5;
    localparam logic [2:0] OP_WR  = 3'h4;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_MRS = 3'h0;

    // mode register field positions
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_LSB = 7;
    localparam int MR_WBL    = 9;
    localparam int AP_BIT    = 10;
    localparam logic [9:0] MR_RESET = 10'h020;
    localparam logic [2:0] BL_FULL  = 3'h7;
    localparam logic [2:0] CL_THREE = 3'h3;

    // timing
    localparam int CLK_NS        = 10;
    localparam int REF_PERIOD_MS = 64;
    localparam int REF_ROWS      = 4096;
    localparam int TRC_NS        = 70;
    localparam int TRC_CYC       = (TRC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SREF_TICK_CYC = (REF_PERIOD_MS * 1000000) / REF_ROWS / CLK_NS;
endpackage

//--- hdl/sdc_fifo.sv
`timescale 1ns/1ps
module sdc_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  store [D];   // word storage
    logic [AW-1:0] wptr;        // next slot to fill
    logic [AW-1:0] rptr;        // oldest slot
    logic [AW:0]   count;       // words held
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    // full and empty come straight from the held count
    assign in_ready  = (count != D[AW:0]);
    assign out_valid = (count != '0);
    assign out_data  = store[rptr];

    // pointers and count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= push ? wptr + 1'b1 : wptr;
            rptr  <= pop ? rptr + 1'b1 : rptr;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // storage has no reset, only written on push
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wptr] <= in_data;
        end
    end
endmodule // sdc_fifo

//--- hdl/sdc_device.sv
`timescale 1ns/1ps
// Behaviour
// R1 - controller keeps test mode bits at zero; the bench sets them with mode 11'h0A0
// R2 - write burst bit forces single-word writes
// R3 - selected all-high encoding starts nothing
// R4 - burst stop ends the running burst
// R5 - burst stop ignored for auto precharge bursts
// R6 - stopped read drains for read latency
// R7 - chip select high ignores all other inputs; the code still acts on cke and dqm then
// R8 - auto refresh advances internal row counter
// R9 - controller issues 4096 refreshes per 64 ms
// R10 - controller refreshes only idle, awake device
// R11 - controller waits row cycle after refresh
// R12 - controller meets precharge time between refreshes
// R13 - refresh with clock enable low: self refresh
// R14 - self refresh exit needs deselect or idle
// R15 - controller idles row cycle after exit
// R16 - controller bursts refreshes around self refresh
// R17 - clock enable low in burst freezes state
// R18 - clock enable low when idle: power-down
// R19 - controller limits suspend and power-down time
// R20 - clock enable high resumes next cycle
// R21 - data mask blocks writes, disables read drive
// R22 - pins sampled and decoded each rising edge; the code decodes commands only while pwr is ST_RUN, except the ST_SREF exit check
module sdc_device (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    // command pins
    input  wire sdc_pkg::sdc_cmd_s         cmd,
    input  wire logic                      cke,
    input  wire logic [1:0]                bank_select,
    input  wire logic [sdc_pkg::ADDR_W-1:0] addr,
    // data pins
    input  wire logic                      dqm,
    input  wire logic [sdc_pkg::DATA_W-1:0] dq_in,
    output logic [sdc_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    // status
    output logic                           write_ready,
    output logic                           self_refresh,
    output logic                           power_down,
    output logic                           clock_suspend,
    output logic                           test_mode_on,
    output logic [sdc_pkg::ROW_W-1:0]      refresh_row
);
    import sdc_pkg::*;

    // burst length field to word count
    function automatic logic [8:0] burst_len(input logic [2:0] f);
        case (f)
            3'h0:    burst_len = 9'h001;
            3'h1:    burst_len = 9'h002;
            3'h2:    burst_len = 9'h004;
            3'h3:    burst_len = 9'h008;
            default: burst_len = 9'h100;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state
    sdc_pwr_e          pwr;          // power condition
    sdc_pwr_e          next_pwr;     // its next value
    logic [9:0]        mode;         // mode register
    logic [3:0]        bank_open;    // one bit per bank
    logic              bst_on;       // burst running
    logic              bst_rd;       // burst is a read
    logic              bst_ap;       // burst closes its bank at the end
    logic              bst_full;     // full page, runs until stopped
    logic [8:0]        bst_left;     // words still to move
    logic [7:0]        bst_i;        // word index within burst
    logic [7:0]        bst_col;      // starting column
    logic [1:0]        bst_bank;     // bank of the burst
    logic [1:0]        rd_vld;       // read latency pipe valid
    logic [DATA_W-1:0] rd_dat [2];   // read latency pipe data
    logic              dqm_q;        // mask seen one edge earlier
    logic [3:0]        trc_cnt;      // array busy after auto refresh
    logic [11:0]       tick;         // self refresh interval timer
    logic [DATA_W-1:0] mem [2**MEM_AW];
    logic              fifo_in_rdy;
    logic              fifo_out_vld;
    sdc_wword_s        fifo_out;

    ////////////////////////////////////////////////////////////////////////////////
    // command decode from the pins of this edge
    wire [2:0] op      = {cmd.ras_n, cmd.cas_n, cmd.we_n};   // see R3
    wire       sel     = !cmd.cs_n;                          // see R7
    wire       live    = (pwr == ST_RUN);                    // see R22
    wire       c_any   = live && sel;
    wire       c_act   = c_any && (op == OP_ACT);
    wire       c_pre   = c_any && (op == OP_PRE);
    wire       c_mrs   = c_any && (op == OP_MRS);
    wire       c_rw    = c_any && (op == OP_RD || op == OP_WR);
    wire       c_aref  = c_any && (op == OP_REF) && cke;     // see R8
    wire       c_sref  = c_any && (op == OP_REF) && !cke;    // see R13
    // stop only reaches bursts without auto precharge
    wire       c_stop  = c_any && (op == OP_BST) && bst_on && !bst_ap; // see R4 R5
    wire       all_idle = (bank_open == 4'h0) && !bst_on;

    // word handled this cycle: a fresh column command or the running burst
    wire       cont    = live && bst_on && !c_stop && !c_rw;
    wire       wd_go   = c_rw || cont;
    wire       wd_rd   = c_rw ? (op == OP_RD) : bst_rd;
    wire [1:0] wd_bank = c_rw ? bank_select : bst_bank;
    wire [7:0] seq_col = bst_col + bst_i;
    wire [7:0] ilv_col = bst_col ^ bst_i;
    wire [7:0] run_col = mode[MR_BT_BIT] ? ilv_col : seq_col;
    wire [7:0] wd_col  = c_rw ? addr[7:0] : run_col;
    wire [MEM_AW-1:0] wd_idx = {wd_bank, wd_col[3:0]};

    // writes always use the programmed length unless single-word is set
    wire [8:0] rd_len  = burst_len(mode[MR_BL_LSB +: 3]);
    wire [8:0] wr_len  = mode[MR_WBL] ? 9'h001 : rd_len;        // see R2
    wire [8:0] new_len = (op == OP_RD) ? rd_len : wr_len;
    wire       new_full = (mode[MR_BL_LSB +: 3] == BL_FULL) && !((op == OP_WR) && mode[MR_WBL]);

    // a masked write word never reaches the array
    wire       wr_push = wd_go && !wd_rd && !dqm;              // see R21
    wire       rd_go   = wd_go && wd_rd;
    wire       burst_end = cont && !bst_full && (bst_left == 9'h001);
    wire       new_end   = c_rw && !new_full && (new_len == 9'h001);
    wire       cl3     = (mode[MR_CL_LSB +: 3] == CL_THREE);
    // array is busy while refresh is in progress, so the queue waits
    wire       drain   = (trc_cnt == 4'h0) && (pwr != ST_SREF);
    wire       sref_exit = cke && (cmd.cs_n || op == OP_NOP);   // see R14
    // drivers go quiet on the very edge that enters power-down
    wire       pdown_go  = (next_pwr == ST_PDOWN);              // see R18

    ////////////////////////////////////////////////////////////////////////////////
    // power condition
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            ST_RUN: begin
                if (c_sref) begin
                    next_pwr = ST_SREF;                         // see R13
                end else if (!cke && bst_on) begin
                    next_pwr = ST_SUSPEND;                      // see R17
                end else if (!cke) begin
                    next_pwr = ST_PDOWN;                        // see R18
                end
            end
            ST_SUSPEND, ST_PDOWN: begin
                if (cke) begin
                    next_pwr = ST_RUN;                          // see R20
                end
            end
            ST_SREF: begin
                // only clock enable together with a deselect or no-operation is seen here
                if (sref_exit) begin
                    next_pwr = ST_RUN;
                end
            end
            default: next_pwr = ST_RUN;
        endcase
    end

    // power flags follow the next condition so they stand from the edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwr           <= ST_RUN;
            self_refresh  <= 1'b0;
            power_down    <= 1'b0;
            clock_suspend <= 1'b0;
        end else begin
            pwr           <= next_pwr;
            self_refresh  <= (next_pwr == ST_SREF);
            power_down    <= (next_pwr == ST_PDOWN);
            clock_suspend <= (next_pwr == ST_SUSPEND);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode register and bank state; bank state only moves when live
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode         <= MR_RESET;
            test_mode_on <= 1'b0;
            bank_open    <= 4'h0;
        end else begin
            if (c_mrs && all_idle) begin
                mode         <= addr[9:0];
                test_mode_on <= (addr[MR_TM_LSB +: 2] != 2'h0);  // see R1
            end
            if (c_act) begin
                bank_open[bank_select] <= 1'b1;
            end else if (c_pre && addr[AP_BIT]) begin
                bank_open <= 4'h0;
            end else if (c_pre) begin
                bank_open[bank_select] <= 1'b0;
            end else if (burst_end && bst_ap) begin
                bank_open[bst_bank] <= 1'b0;
            end else if (new_end && addr[AP_BIT]) begin
                bank_open[bank_select] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst engine; nothing here moves while suspended
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bst_on   <= 1'b0;
            bst_rd   <= 1'b0;
            bst_ap   <= 1'b0;
            bst_full <= 1'b0;
            bst_left <= 9'h000;
            bst_i    <= 8'h00;
            bst_col  <= 8'h00;
            bst_bank <= 2'h0;
        end else if (c_rw) begin
            bst_on   <= !new_end;                               // see R2
            bst_rd   <= (op == OP_RD);
            bst_ap   <= addr[AP_BIT];
            bst_full <= new_full;
            bst_left <= new_len - 9'h001;
            bst_i    <= 8'h01;
            bst_col  <= addr[7:0];
            bst_bank <= bank_select;
        end else if (c_stop) begin
            bst_on <= 1'b0;                                     // see R4
        end else if (cont) begin
            bst_on   <= !burst_end;
            bst_left <= bst_left - 9'h001;
            bst_i    <= bst_i + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read latency pipe; words already launched keep flowing after a stop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_vld <= 2'h0;
            dqm_q  <= 1'b1;
            dq_oe  <= 1'b0;
        end else if (live) begin
            rd_vld <= {rd_vld[0], rd_go};                       // see R6
            dqm_q  <= dqm;
            // the mask gates the drivers one edge after it is seen
            dq_oe  <= (cl3 ? rd_vld[1] : rd_vld[0]) && !dqm_q && !pdown_go;  // see R21
        end else begin
            dq_oe  <= 1'b0;
        end
    end

    // read data, held while the internal clock is masked
    always_ff @(posedge sys_clk) begin
        if (live) begin
            rd_dat[0] <= mem[wd_idx];
            rd_dat[1] <= rd_dat[0];
            dq_out    <= cl3 ? rd_dat[1] : rd_dat[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // refresh row counter; self refresh times itself
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            refresh_row <= '0;
            trc_cnt     <= 4'h0;
            tick        <= 12'h000;
        end else begin
            if (c_aref) begin
                refresh_row <= refresh_row + 12'h001;           // see R8
                trc_cnt     <= 4'(TRC_CYC);
            end else if (pwr == ST_SREF && tick == 12'(SREF_TICK_CYC - 1)) begin
                refresh_row <= refresh_row + 12'h001;           // see R13
                trc_cnt     <= 4'(TRC_CYC);
            end else if (trc_cnt != 4'h0) begin
                trc_cnt <= trc_cnt - 4'h1;
            end
            if (pwr != ST_SREF || tick == 12'(SREF_TICK_CYC - 1)) begin
                tick <= 12'h000;
            end else begin
                tick <= tick + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write queue: words wait here while the array is refreshing
    sdc_fifo #(.W($bits(sdc_wword_s)), .D(FIFO_D)) u_wq (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (wr_push),
        .in_ready  (fifo_in_rdy),
        .in_data   ({wd_idx, dq_in}),
        .out_valid (fifo_out_vld),
        .out_ready (drain),
        .out_data  (fifo_out)
    );

    // the controller must hold writes while this is low, else words drop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            write_ready <= 1'b1;
        end else begin
            write_ready <= fifo_in_rdy;
        end
    end

    // array; reads see the array only, not words still queued
    always_ff @(posedge sys_clk) begin
        if (fifo_out_vld && drain) begin
            mem[fifo_out.idx] <= fifo_out.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_nop_starts: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
        c_any && op == OP_NOP && !bst_on |=> !bst_on)
        else $error("no-operation started a burst");
    chk_stop_ends: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
        c_stop |=> !bst_on)
        else $error("burst stop left burst running");
    chk_stop_ap: assert property (@(posedge sys_clk) disable iff (!rstn) // see R5
        c_any && op == OP_BST && bst_ap && cont && !burst_end |=> bst_on)
        else $error("auto precharge burst was stopped");
    chk_read_drain: assert property (@(posedge sys_clk) disable iff (!rstn) // see R6
        c_stop && bst_rd && rd_vld[0] && !cl3 && !dqm_q |=> dq_oe)
        else $error("read data cut off after stop");
    chk_deselect: assert property (@(posedge sys_clk) disable iff (!rstn) // see R7
        cmd.cs_n && live && !bst_on |=> $stable(bank_open) && $stable(mode))
        else $error("deselected cycle changed state");
    chk_ref_row: assert property (@(posedge sys_clk) disable iff (!rstn) // see R8
        c_aref |=> refresh_row == $past(refresh_row) + 12'h001 && trc_cnt == 4'(TRC_CYC))
        else $error("auto refresh row not advanced");
    chk_sref_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see R13
        c_sref ##1 !cke [*3] |=> self_refresh)
        else $error("self refresh left with clock enable low");
    chk_single_wr: assert property (@(posedge sys_clk) disable iff (!rstn) // see R2
        c_rw && op == OP_WR && mode[MR_WBL] |=> !bst_on)
        else $error("single-word write ran as burst");
    chk_suspend: assert property (@(posedge sys_clk) disable iff (!rstn) // see R17
        live && bst_on && !cke && !c_rw && !c_stop |=> ##1 $stable(bst_left) && $stable(bst_i))
        else $error("burst moved while suspended");
    chk_pdown: assert property (@(posedge sys_clk) disable iff (!rstn) // see R18
        live && !cke && all_idle && !c_rw && !c_sref |=> power_down && !dq_oe)
        else $error("idle device missed power-down");
    chk_wake: assert property (@(posedge sys_clk) disable iff (!rstn) // see R20
        (pwr == ST_PDOWN || pwr == ST_SUSPEND) && cke |=> live)
        else $error("clock enable high did not resume");
    chk_mask_wr: assert property (@(posedge sys_clk) disable iff (!rstn) // see R21
        wd_go && !wd_rd && dqm && !fifo_out_vld |=> !fifo_out_vld)
        else $error("masked word queued");

    cov_read: cover property (@(posedge sys_clk) disable iff (!rstn) rd_go ##[2:3] dq_oe);
    cov_stop: cover property (@(posedge sys_clk) disable iff (!rstn) c_stop);
    cov_sref: cover property (@(posedge sys_clk) disable iff (!rstn) self_refresh ##1 !self_refresh);
    cov_full: cover property (@(posedge sys_clk) disable iff (!rstn) !write_ready);
endmodule // sdc_device

//--- bench/sdc_ctrl_model.sv
`timescale 1ns/1ps
// memory controller stand-in: one command slot per clock
module sdc_ctrl_model (
    // clock
    input  wire logic                  sys_clk,
    // command pins
    output sdc_pkg::sdc_cmd_s          cmd,
    output logic                       cke,
    output logic [1:0]                 bank_select,
    output logic [sdc_pkg::ADDR_W-1:0] addr,
    // data pins
    output logic                       dqm,
    output logic [sdc_pkg::DATA_W-1:0] dq_in
);
    import sdc_pkg::*;
    ////////////////////////////////////////////////////////////
    // pins at time zero: deselected, clock enabled
    initial begin
        cmd = 4'hF;
        cke = 1'b1;
        bank_select = 2'h1;
        addr = 11'h000;
        dqm = 1'b0;
        dq_in = 32'h0;
    end
    // drive just after the edge, held until the next edge samples it
    task automatic put(input logic c, input logic [2:0] o, input logic [10:0] a,
                       input logic k, input logic m, input logic v, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        cmd = {c, o};
        addr = a;
        cke = k;
        dqm = m;
        // released data lines toggle so a stale word never looks valid
        dq_in = v ? d : ~dq_in;
    endtask
    // one refresh, then only no_operation for the row cycle
    task automatic refresh();
        put(1'b0, OP_REF, 11'h7FF, 1'b1, 1'b0, 1'b0, 32'h0);
        repeat (TRC_CYC) put(1'b0, OP_NOP, 11'h0, 1'b1, 1'b0, 1'b0, 32'h0);
    endtask
endmodule // sdc_ctrl_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sdc_pkg::*;
    // device pins
    logic              sys_clk;
    logic              rstn;
    sdc_cmd_s          cmd;
    logic              cke;
    logic [1:0]        bank_select;
    logic [ADDR_W-1:0] addr;
    logic              dqm;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              write_ready;
    logic              self_refresh;
    logic              power_down;
    logic              clock_suspend;
    logic              test_mode_on;
    logic [ROW_W-1:0]  refresh_row;
    // bookkeeping
    int                miscompares;
    int                samples_checked;
    int                n;
    sdc_device sdc_device_inst (.sys_clk, .rstn, .cmd, .cke, .bank_select, .addr, .dqm,
        .dq_in, .dq_out, .dq_oe, .write_ready, .self_refresh, .power_down, .clock_suspend,
        .test_mode_on, .refresh_row);
    sdc_ctrl_model sdc_ctrl_model_inst (.sys_clk, .cmd, .cke, .bank_select, .addr, .dqm,
        .dq_in);
    ////////////////////////////////////////////////////////////
    // one compare, counted either way
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // short hands for the controller slot
    task automatic p(input logic c, input logic [2:0] o, input logic [10:0] a,
                     input logic k, input logic m, input logic v, input logic [31:0] d);
        sdc_ctrl_model_inst.put(c, o, a, k, m, v, d);
    endtask
    task automatic op(input logic [2:0] o, input logic [10:0] a);
        p(1'b0, o, a, 1'b1, 1'b0, 1'b0, 32'h0);
    endtask
    task automatic no_operation(input int k);
        repeat (k) op(OP_NOP, 11'h0);
    endtask
    // one read at latency two: quiet at the command edge, driving one edge later
    task automatic rd(input logic [10:0] col, input logic [31:0] exp);
        op(OP_RD, col);
        no_operation(1);
        check("oe early", dq_oe, 0);
        no_operation(1);
        check("oe", dq_oe, 1);
        check("read word", dq_out, exp);
    endtask
    // idle slots with a given mask, counting cycles that drive data
    task automatic count_oe(input int k, input logic msk);
        n = 0;
        repeat (k) begin
            // the slot standing now counts too, it is what the stop edge sees
            n += (dq_oe === 1'b1);
            p(1'b0, OP_NOP, 11'h0, 1'b1, msk, 1'b0, 32'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // free running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // main sequence
    initial begin
        miscompares = 0;
        samples_checked = 0;
        rstn = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        check("status", {dq_oe, write_ready, self_refresh, power_down, clock_suspend,
            test_mode_on}, 6'h10);
        check("row", refresh_row, 0);
        $display("test reset done");
        // vendor test bits, then back to normal
        op(OP_MRS, 11'h0A0);
        no_operation(2);
        check("test mode", test_mode_on, 1);
        op(OP_MRS, 11'h020);
        no_operation(2);
        check("test mode", test_mode_on, 0);
        $display("test mode done");
        // masked write must not land; masked read must not drive
        op(OP_ACT, 11'h0);
        no_operation(2);
        p(1'b0, OP_WR, 11'h4, 1'b1, 1'b0, 1'b1, 32'hA5A50001);
        no_operation(1);
        p(1'b0, OP_WR, 11'h4, 1'b1, 1'b1, 1'b1, 32'h0BAD0BAD);
        p(1'b0, OP_WR, 11'h9, 1'b1, 1'b0, 1'b1, 32'h5A5A0009);
        no_operation(8);
        rd(11'h4, 32'hA5A50001);
        rd(11'h9, 32'h5A5A0009);
        p(1'b0, OP_NOP, 11'h0, 1'b1, 1'b1, 1'b0, 32'h0);
        p(1'b0, OP_RD, 11'h4, 1'b1, 1'b1, 1'b0, 32'h0);
        count_oe(4, 1'b1);
        check("masked read", n, 0);
        $display("test mask done");
        // burst four with single-word writes: the neighbour keeps its word
        op(OP_PRE, 11'h400);
        no_operation(2);
        op(OP_MRS, 11'h222);
        op(OP_ACT, 11'h0);
        no_operation(2);
        p(1'b0, OP_WR, 11'h8, 1'b1, 1'b0, 1'b1, 32'h11110008);
        for (int i = 1; i < 4; i++) begin
            p(1'b0, OP_NOP, 11'h0, 1'b1, 1'b0, 1'b1, 32'h22220000 + i);
        end
        no_operation(8);
        rd(11'h8, 32'h11110008);
        no_operation(1);
        check("single write", dq_out, 32'h5A5A0009);
        $display("test write length done");
        // stop cuts a plain burst but not one with auto precharge
        no_operation(3);
        op(OP_RD, 11'h8);
        op(OP_BST, 11'h0);
        count_oe(6, 1'b0);
        check("stopped", n < 4, 1);
        op(OP_RD, 11'h408);
        op(OP_BST, 11'h0);
        count_oe(6, 1'b0);
        check("precharge burst", n, 4);
        // full page: suspend mid burst, resume, then stop drains latency cycles
        op(OP_MRS, 11'h027);
        op(OP_ACT, 11'h0);
        no_operation(2);
        op(OP_RD, 11'h0);
        no_operation(2);
        repeat (2) p(1'b0, OP_NOP, 11'h0, 1'b0, 1'b0, 1'b0, 32'h0);
        check("suspend", clock_suspend, 1);
        no_operation(2);
        check("resume", clock_suspend, 0);
        op(OP_BST, 11'h0);
        count_oe(6, 1'b0);
        check("drain", n, 2);
        $display("test burst stop done");
        // refresh, then deselected commands change nothing
        op(OP_PRE, 11'h400);
        no_operation(2);
        sdc_ctrl_model_inst.refresh();
        sdc_ctrl_model_inst.refresh();
        check("row", refresh_row, 2);
        p(1'b1, OP_MRS, 11'h080, 1'b1, 1'b0, 1'b0, 32'h0);
        p(1'b1, OP_REF, 11'h0, 1'b1, 1'b0, 1'b0, 32'h0);
        no_operation(4);
        check("deselect", {test_mode_on, dq_oe, refresh_row}, 14'h2);
        // idle with clock enable low is power-down, kept short
        repeat (3) p(1'b0, OP_NOP, 11'h0, 1'b0, 1'b0, 1'b0, 32'h0);
        check("power down", power_down, 1);
        no_operation(2);
        check("power up", power_down, 0);
        sdc_ctrl_model_inst.refresh();
        check("row", refresh_row, 3);
        $display("test refresh done");
        // self refresh: commands ignored, row advances on the internal tick
        p(1'b0, OP_REF, 11'h0, 1'b0, 1'b0, 1'b0, 32'h0);
        p(1'b1, OP_NOP, 11'h0, 1'b0, 1'b0, 1'b0, 32'h0);
        check("self refresh", self_refresh, 1);
        for (n = 0; n < SREF_TICK_CYC + 4 && refresh_row === 12'h3; n++) begin
            p(1'b0, OP_MRS, 11'h080, 1'b0, 1'b0, 1'b0, 32'h0);
        end
        if (n == SREF_TICK_CYC + 4) begin
            // an internal tick that never comes counts against the run
            miscompares++;
        end else begin
            check("self row", {test_mode_on, refresh_row}, 13'h4);
            repeat (2) p(1'b1, OP_NOP, 11'h0, 1'b1, 1'b0, 1'b0, 32'h0);
            check("self exit", self_refresh, 0);
            no_operation(TRC_CYC);
            sdc_ctrl_model_inst.refresh();
            check("row", refresh_row, 5);
        end
        $display("test self refresh done");
        final_report();
    end
endmodule // tb_top
